// ==== lcd_pkg.sv ====
/*
  Shared constants for the LCD driver configuration and state block:
  command register offsets, field positions, reset values and encodings.
  Assumes an 8-bit command data path and a 4-bit register address.
*/
package lcd_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [3:0] REG_DISP    = 4'h0;
  localparam logic [3:0] REG_EXT0    = 4'h1;
  localparam logic [3:0] REG_EXT1    = 4'h2;
  localparam logic [3:0] REG_HVPC    = 4'h3;
  localparam logic [3:0] REG_VPR     = 4'h4;
  localparam logic [3:0] REG_XADDR   = 4'h5;
  localparam logic [3:0] REG_YADDR   = 4'h6;
  localparam logic [3:0] REG_START   = 4'h7;
  localparam logic [3:0] REG_INITROW = 4'h8;
  localparam logic [3:0] REG_MUX     = 4'h9;
  localparam logic [3:0] REG_SWRST   = 4'hA;
  localparam logic [3:0] REG_STATUS  = 4'hB;
  localparam logic [3:0] REG_DATA    = 4'hC;

  // ==========================================================================
  // Field positions in the display control register.
  localparam int DISP_ON_BIT   = 0;
  localparam int DISP_INV_BIT  = 1;
  localparam int DISP_DAL_BIT  = 2;
  localparam int DISP_MX_BIT   = 3;
  localparam int DISP_MY_BIT   = 4;
  localparam int DISP_CAL_BIT  = 5;
  localparam int DISP_OSC_BIT  = 6;
  localparam int DISP_PSM_BIT  = 7;

  // Field positions in extended configuration register 0.
  localparam int EXT0_FR_LSB   = 0;
  localparam int EXT0_TC_LSB   = 2;
  localparam int EXT0_PUMP_LSB = 5;

  // Field positions in extended configuration register 1.
  localparam int EXT1_VERT_BIT = 0;
  localparam int EXT1_DOR_BIT  = 1;
  localparam int EXT1_ICON_BIT = 2;
  localparam int EXT1_BRM_BIT  = 3;
  localparam int EXT1_P4_BIT   = 4;
  localparam int EXT1_EXTC_BIT = 5;

  // ==========================================================================
  // Reset values: power-save on, frame rate 11, coefficient 010, pump 100.
  localparam logic [7:0] DISP_RST    = 8'h80;
  localparam logic [7:0] EXT0_RST    = 8'h8B;
  localparam logic [7:0] EXT1_RST    = 8'h00;
  localparam logic [7:0] HVPC_RST    = 8'h00;
  localparam logic [7:0] VPR_RST     = 8'h00;
  localparam logic [6:0] MUX_FULL    = 7'h50;
  localparam logic [6:0] MUX_64      = 7'h40;

  // ==========================================================================
  // Addressing limits and special rows.
  localparam logic [6:0] COL_MAX     = 7'h7F;
  localparam logic [3:0] BANK_MAX    = 4'h9;
  localparam logic [3:0] ICON_BANK   = 4'h9;
  localparam logic [6:0] ICON_ROW    = 7'h4F;
  localparam logic [6:0] LINE_BANNED = 7'h48;

  // Frame rate decode, in Hz.
  localparam logic [7:0] FR_HZ_00    = 8'h1E;
  localparam logic [7:0] FR_HZ_01    = 8'h28;
  localparam logic [7:0] FR_HZ_10    = 8'h32;
  localparam logic [7:0] FR_HZ_11    = 8'h3C;

  // ==========================================================================
  // Drive mode of the row and column outputs.
  typedef enum logic [1:0] {
    PIX_GND    = 2'b00,
    PIX_NORMAL = 2'b01,
    PIX_INV    = 2'b10,
    PIX_ALL_ON = 2'b11
  } lcd_pix_t;

endpackage

// ==== lcd_field.sv ====
/*
  One command-loaded configuration register with its own reset value.
  Assumes load and soft reset are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps

module lcd_field #(
  parameter int              W   = 8,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_soft_rst,
  input  wire logic          i_load,
  input  wire logic [W-1:0]  i_d,
  output logic      [W-1:0]  o_q
);

  // ==========================================================================
  // Storage.
  // The soft reset wins over a load in the same cycle so that a reset
  // command always leaves the documented state behind.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_q <= RST;
    end
    else if (i_soft_rst)
    begin
      o_q <= RST;
    end
    else if (i_load)
    begin
      o_q <= i_d;
    end
  end

endmodule

// ==== lcd_drv_config_state.sv ====
/*
  Configuration and state logic of a 128 x 80 matrix LCD driver: command
  registers, power-save and display mode, RAM address counter, start line
  and initial row. Assumes a host that writes commands over a plain
  register port on the core clock, and an outside RAM and drive stage.
*/
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps

module lcd_drv_config_state (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  output logic             o_power_save,
  output logic             o_osc_en,
  output logic             o_ext_clk_sel,
  output logic             o_hv_gen_en,
  output logic             o_bias_gen_en,
  output logic [1:0]       o_pix_mode,
  output logic             o_frame_cal_run,
  output logic [7:0]       o_frame_rate_hz,
  output logic [2:0]       o_temp_coeff_sel,
  output logic [2:0]       o_pump_mult,
  output logic [7:0]       o_supply_prog_value,
  output logic             o_vertical_addr,
  output logic             o_bit_order_sel,
  output logic             o_bottom_row_mirror,
  output logic             o_y_mirror,
  output logic             o_icon_row_en,
  output logic [3:0]       o_icon_bank,
  output logic             o_p_four,
  output logic [6:0]       o_mux_rows,
  output logic [6:0]       o_start_line,
  output logic [6:0]       o_init_row,
  output logic             o_ram_we,
  output logic [3:0]       o_ram_bank,
  output logic [6:0]       o_ram_col,
  output logic [7:0]       o_ram_wdata
);

  // ==========================================================================
  // Command decode.
  logic       soft_rst;
  logic       wr_disp;
  logic       wr_ext0;
  logic       wr_ext1;
  logic       wr_hvpc;
  logic       wr_vpr;
  logic       wr_data;

  assign soft_rst = i_wr && (i_addr == lcd_pkg::REG_SWRST);
  assign wr_disp  = i_wr && (i_addr == lcd_pkg::REG_DISP);
  assign wr_ext0  = i_wr && (i_addr == lcd_pkg::REG_EXT0);
  assign wr_ext1  = i_wr && (i_addr == lcd_pkg::REG_EXT1);
  assign wr_hvpc  = i_wr && (i_addr == lcd_pkg::REG_HVPC);
  assign wr_vpr   = i_wr && (i_addr == lcd_pkg::REG_VPR);
  assign wr_data  = i_wr && (i_addr == lcd_pkg::REG_DATA);

  // ==========================================================================
  // Command-loaded fields.
  logic [7:0] disp_reg;
  logic [7:0] ext0_reg;
  logic [7:0] ext1_reg;
  logic [7:0] hvpc_reg;
  logic [7:0] vpr_reg;

  lcd_field #(.W(8), .RST(lcd_pkg::DISP_RST)) u_disp (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_soft_rst (soft_rst),
    .i_load     (wr_disp),
    .i_d        (i_wdata),
    .o_q        (disp_reg)
  );

  lcd_field #(.W(8), .RST(lcd_pkg::EXT0_RST)) u_ext0 (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_soft_rst (soft_rst),
    .i_load     (wr_ext0),
    .i_d        (i_wdata),
    .o_q        (ext0_reg)
  );

  lcd_field #(.W(8), .RST(lcd_pkg::EXT1_RST)) u_ext1 (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_soft_rst (soft_rst),
    .i_load     (wr_ext1),
    .i_d        ({2'h0, i_wdata[5:0]}),
    .o_q        (ext1_reg)
  );

  lcd_field #(.W(8), .RST(lcd_pkg::HVPC_RST)) u_hvpc (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_soft_rst (soft_rst),
    .i_load     (wr_hvpc),
    .i_d        ({6'h00, i_wdata[1:0]}),
    .o_q        (hvpc_reg)
  );

  lcd_field #(.W(8), .RST(lcd_pkg::VPR_RST)) u_vpr (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_soft_rst (soft_rst),
    .i_load     (wr_vpr),
    .i_d        (i_wdata),
    .o_q        (vpr_reg)
  );

  logic       display_on;
  logic       inverse;
  logic       all_pixels_on;
  logic       x_mirror;
  logic       osc_start;
  logic       psm_cmd;
  logic       icon_en;

  assign display_on    = disp_reg[lcd_pkg::DISP_ON_BIT];
  assign inverse       = disp_reg[lcd_pkg::DISP_INV_BIT];
  assign all_pixels_on = disp_reg[lcd_pkg::DISP_DAL_BIT];
  assign x_mirror      = disp_reg[lcd_pkg::DISP_MX_BIT];
  assign osc_start     = disp_reg[lcd_pkg::DISP_OSC_BIT];
  assign psm_cmd       = disp_reg[lcd_pkg::DISP_PSM_BIT];
  assign icon_en       = ext1_reg[lcd_pkg::EXT1_ICON_BIT];

  // ==========================================================================
  // Addressing registers with range checks.
  logic [6:0] col_reg;
  logic [3:0] bank_reg;
  logic [6:0] start_reg;
  logic [6:0] row_reg;
  logic [6:0] mux_reg;
  logic [6:0] col_next;
  logic [3:0] bank_next;
  logic [6:0] line_step;
  logic       line_ok;

  // A partial mux whose height is a multiple of 16, other than 64, forces a coarser
  // grid; the widest grid that still fits the mux keeps every legal choice.
  always_comb
  begin
    line_step = icon_en ? 7'h10 : 7'h08;
    if (mux_reg[3:0] == 4'h0 && mux_reg != lcd_pkg::MUX_FULL &&
        mux_reg != lcd_pkg::MUX_64)
    begin
      line_step = 7'h10;
    end
  end

  assign line_ok = ((i_wdata[6:0] & (line_step - 7'h01)) == 7'h00) &&
                   (i_wdata[6:0] != lcd_pkg::LINE_BANNED) &&
                   (i_wdata[6:0] < lcd_pkg::MUX_FULL);

  // Horizontal mode walks columns first, vertical mode walks banks first.
  always_comb
  begin
    col_next  = col_reg;
    bank_next = bank_reg;
    if (!ext1_reg[lcd_pkg::EXT1_VERT_BIT])
    begin
      col_next = col_reg + 7'h01;
      if (col_reg == lcd_pkg::COL_MAX)
      begin
        bank_next = (bank_reg == lcd_pkg::BANK_MAX) ? 4'h0 :
                    bank_reg + 4'h1;
      end
    end
    else
    begin
      bank_next = (bank_reg == lcd_pkg::BANK_MAX) ? 4'h0 :
                  bank_reg + 4'h1;
      if (bank_reg == lcd_pkg::BANK_MAX)
      begin
        col_next = col_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      col_reg  <= 7'h00;
      bank_reg <= 4'h0;
    end
    else if (soft_rst)
    begin
      col_reg  <= 7'h00;
      bank_reg <= 4'h0;
    end
    else if (wr_data)
    begin
      col_reg  <= col_next;
      bank_reg <= bank_next;
    end
    else if (i_wr && i_addr == lcd_pkg::REG_XADDR)
    begin
      col_reg <= i_wdata[6:0];
    end
    else if (i_wr && i_addr == lcd_pkg::REG_YADDR &&
             i_wdata[3:0] <= lcd_pkg::BANK_MAX)
    begin
      bank_reg <= i_wdata[3:0];
    end
  end

  // Illegal start lines and an initial row on the enabled icon row are ignored,
  // so the previous legal value stays in force.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      start_reg <= 7'h00;
      row_reg   <= 7'h00;
      mux_reg   <= lcd_pkg::MUX_FULL;
    end
    else if (soft_rst)
    begin
      start_reg <= 7'h00;
      row_reg   <= 7'h00;
      mux_reg   <= lcd_pkg::MUX_FULL;
    end
    else if (i_wr)
    begin
      if (i_addr == lcd_pkg::REG_START && line_ok)
      begin
        start_reg <= i_wdata[6:0];
      end
      if (i_addr == lcd_pkg::REG_INITROW &&
          i_wdata[6:0] <= lcd_pkg::ICON_ROW &&
          !(icon_en && i_wdata[6:0] == lcd_pkg::ICON_ROW))
      begin
        row_reg <= i_wdata[6:0];
      end
      if (i_addr == lcd_pkg::REG_MUX && i_wdata[2:0] == 3'h0 &&
          i_wdata[6:0] != 7'h00 && i_wdata[6:0] <= lcd_pkg::MUX_FULL)
      begin
        mux_reg <= i_wdata[6:0];
      end
    end
  end

  // ==========================================================================
  // Power and display mode.
  logic       ps_now;
  logic       osc_now;
  logic [1:0] pix_now;
  logic [2:0] pump_now;
  logic [7:0] fr_now;

  assign ps_now  = psm_cmd || (!display_on && all_pixels_on);
  assign osc_now = osc_start && !ps_now;

  always_comb
  begin
    if (!osc_now || !display_on)
    begin
      pix_now = lcd_pkg::PIX_GND;
    end
    else if (all_pixels_on)
    begin
      pix_now = lcd_pkg::PIX_ALL_ON;
    end
    else if (inverse)
    begin
      pix_now = lcd_pkg::PIX_INV;
    end
    else
    begin
      pix_now = lcd_pkg::PIX_NORMAL;
    end
  end

  always_comb
  begin
    case (ext0_reg[lcd_pkg::EXT0_PUMP_LSB +: 3])
      3'b000:  pump_now = 3'h2;
      3'b001:  pump_now = 3'h3;
      3'b010:  pump_now = 3'h4;
      3'b011:  pump_now = 3'h5;
      3'b100:  pump_now = 3'h4;
      3'b101:  pump_now = 3'h5;
      3'b110:  pump_now = 3'h6;
      default: pump_now = 3'h7;
    endcase
  end

  always_comb
  begin
    case (ext0_reg[lcd_pkg::EXT0_FR_LSB +: 2])
      2'b00:   fr_now = lcd_pkg::FR_HZ_00;
      2'b01:   fr_now = lcd_pkg::FR_HZ_01;
      2'b10:   fr_now = lcd_pkg::FR_HZ_10;
      default: fr_now = lcd_pkg::FR_HZ_11;
    endcase
  end

  // Outputs are registered, so every decoded state shows two cycles after
  // the command that caused it, one cycle after its field register loads.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_power_save        <= 1'b1;
      o_osc_en            <= 1'b0;
      o_hv_gen_en         <= 1'b0;
      o_bias_gen_en       <= 1'b0;
      o_pix_mode          <= lcd_pkg::PIX_GND;
      o_frame_cal_run     <= 1'b0;
      o_ext_clk_sel       <= 1'b0;
      o_frame_rate_hz     <= lcd_pkg::FR_HZ_11;
      o_temp_coeff_sel    <= 3'h2;
      o_pump_mult         <= 3'h4;
      o_supply_prog_value <= 8'h00;
    end
    else
    begin
      o_power_save        <= ps_now;
      o_osc_en            <= osc_now;
      o_hv_gen_en         <= osc_now && (hvpc_reg[1:0] != 2'h0);
      o_bias_gen_en       <= osc_now;
      o_pix_mode          <= pix_now;
      o_frame_cal_run     <= disp_reg[lcd_pkg::DISP_CAL_BIT] && osc_now;
      o_ext_clk_sel       <= ext1_reg[lcd_pkg::EXT1_EXTC_BIT];
      o_frame_rate_hz     <= fr_now;
      o_temp_coeff_sel    <= ext0_reg[lcd_pkg::EXT0_TC_LSB +: 3];
      o_pump_mult         <= pump_now;
      o_supply_prog_value <= vpr_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_vertical_addr     <= 1'b0;
      o_bit_order_sel     <= 1'b0;
      o_bottom_row_mirror <= 1'b0;
      o_y_mirror          <= 1'b0;
      o_icon_row_en       <= 1'b0;
      o_icon_bank         <= lcd_pkg::ICON_BANK;
      o_p_four            <= 1'b0;
      o_mux_rows          <= lcd_pkg::MUX_FULL;
      o_start_line        <= 7'h00;
      o_init_row          <= 7'h00;
    end
    else
    begin
      o_vertical_addr     <= ext1_reg[lcd_pkg::EXT1_VERT_BIT];
      o_bit_order_sel     <= ext1_reg[lcd_pkg::EXT1_DOR_BIT];
      o_bottom_row_mirror <= ext1_reg[lcd_pkg::EXT1_BRM_BIT];
      o_y_mirror          <= disp_reg[lcd_pkg::DISP_MY_BIT];
      o_icon_row_en       <= icon_en;
      o_icon_bank         <= lcd_pkg::ICON_BANK;
      o_p_four            <= ext1_reg[lcd_pkg::EXT1_P4_BIT] &&
                             (mux_reg == lcd_pkg::MUX_64 ||
                              mux_reg == lcd_pkg::MUX_FULL);
      o_mux_rows          <= mux_reg;
      o_start_line        <= start_reg;
      o_init_row          <= row_reg;
    end
  end

  // ==========================================================================
  // RAM write port. The mirror is applied at write time only, so a change
  // of the X-mirror bit leaves the image already in RAM as it was.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ram_we    <= 1'b0;
      o_ram_bank  <= 4'h0;
      o_ram_col   <= 7'h00;
      o_ram_wdata <= 8'h00;
    end
    else
    begin
      o_ram_we    <= wr_data;
      if (wr_data)
      begin
        o_ram_bank  <= bank_reg;
        o_ram_col   <= x_mirror ? (lcd_pkg::COL_MAX - col_reg) :
                       col_reg;
        o_ram_wdata <= i_wdata;
      end
    end
  end

  // ==========================================================================
  // Read port: data stand in the cycle after the read strobe.
  logic [7:0] rd_now;

  always_comb
  begin
    case (i_addr)
      lcd_pkg::REG_DISP:    rd_now = disp_reg;
      lcd_pkg::REG_EXT0:    rd_now = ext0_reg;
      lcd_pkg::REG_EXT1:    rd_now = ext1_reg;
      lcd_pkg::REG_HVPC:    rd_now = hvpc_reg;
      lcd_pkg::REG_VPR:     rd_now = vpr_reg;
      lcd_pkg::REG_XADDR:   rd_now = {1'b0, col_reg};
      lcd_pkg::REG_YADDR:   rd_now = {4'h0, bank_reg};
      lcd_pkg::REG_START:   rd_now = {1'b0, start_reg};
      lcd_pkg::REG_INITROW: rd_now = {1'b0, row_reg};
      lcd_pkg::REG_MUX:     rd_now = {1'b0, mux_reg};
      lcd_pkg::REG_STATUS:  rd_now = {3'h0, o_p_four, o_hv_gen_en,
                                      o_osc_en, display_on, o_power_save};
      default:              rd_now = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
    end
    else
    begin
      o_rdata <= i_rd ? rd_now : 8'h00;
    end
  end

endmodule

// ==== lcd_cfg_checker.sv ====
/*
  Concurrent checks on the ports of the LCD configuration block.
  Assumes it is bound to the top module; it only observes its ports.
*/
`timescale 1ns/1ps

module lcd_cfg_checker (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        o_power_save,
  input  wire logic        o_osc_en,
  input  wire logic        o_hv_gen_en,
  input  wire logic        o_bias_gen_en,
  input  wire logic [1:0]  o_pix_mode,
  input  wire logic        o_frame_cal_run,
  input  wire logic [7:0]  o_frame_rate_hz,
  input  wire logic [2:0]  o_temp_coeff_sel,
  input  wire logic [2:0]  o_pump_mult,
  input  wire logic        o_icon_row_en,
  input  wire logic [3:0]  o_icon_bank,
  input  wire logic        o_p_four,
  input  wire logic [6:0]  o_mux_rows,
  input  wire logic [6:0]  o_start_line,
  input  wire logic [6:0]  o_init_row,
  input  wire logic        o_ram_we,
  input  wire logic [3:0]  o_ram_bank
);
  // ========================================
  // Clocking and reset
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ========================================
  // Properties
  a_reset_vals: assert property ($rose(i_rst_n) |-> o_power_save &&
    o_frame_rate_hz == 8'h3C && o_temp_coeff_sel == 3'h2 &&
    o_pump_mult == 3'h4 && o_mux_rows == 7'h50 && !o_osc_en)
    else $error("state after reset is wrong");
  a_ps_entry: assert property (i_wr && i_addr == 4'h0 && i_wdata[7] ##1
    !(i_wr && i_addr == 4'h0) |-> ##1 o_power_save)
    else $error("power-save command not obeyed");
  a_ps_grounds: assert property (o_power_save |-> o_pix_mode == 2'h0 &&
    !o_osc_en && !o_hv_gen_en && !o_bias_gen_en)
    else $error("power-save leaves something running");
  a_cal_needs_osc: assert property (o_frame_cal_run |-> o_osc_en)
    else $error("calibration without oscillator");
  a_icon_bank: assert property (o_icon_bank == 4'h9)
    else $error("icon bank is not 9");
  a_ram_write: assert property (o_ram_we |-> o_ram_bank <= 4'h9 &&
    $past(i_wr) && $past(i_addr) == 4'hC)
    else $error("RAM write without data command or bank out of range");
  a_start_step: assert property (o_start_line[2:0] == 3'h0 &&
    o_start_line != 7'h48 && o_start_line < 7'h50)
    else $error("illegal start line");
  a_init_icon: assert property (o_icon_row_en |-> o_init_row != 7'h4F)
    else $error("initial row on the icon row");
  a_p_four_mux: assert property (o_p_four |->
    o_mux_rows == 7'h40 || o_mux_rows == 7'h50)
    else $error("fixed p at a partial mux rate");
  a_hold_fields: assert property (!(i_wr && (i_addr == 4'h1 ||
    i_addr == 4'hA)) [*2] |=> $stable(o_frame_rate_hz))
    else $error("frame rate changed without a command");
endmodule

// ==== lcd_host_model.sv ====
/*
  Host controller model: drives the reset pin and the register port.
  Assumes the testbench calls its tasks one at a time.
*/
`timescale 1ns/1ps

module lcd_host_model (
  input  wire logic        i_core_clk,
  input  wire logic [7:0]  i_rdata,
  output logic             o_rst_n,
  output logic [3:0]       o_addr,
  output logic [7:0]       o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial
  begin
    o_rst_n = 1'b0;
    o_addr  = 4'h0;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // Power-on always goes through the pin; the command is only used mid-run.
  task automatic pin_reset();
    o_rst_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    o_rst_n <= 1'b1;
  endtask

  // Released data is inverted so a stale value is never mistaken for live.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_core_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
    @(posedge i_core_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_core_clk);
    o_rd   <= 1'b0;
    @(posedge i_core_clk);
    d = i_rdata;
  endtask
endmodule

// ==== tb.sv ====
/*
  Self-checking testbench of the LCD configuration block.
  Assumes the host model file and the checker file are compiled first.
*/
`timescale 1ns/1ps

module tb;
  logic i_core_clk, i_rst_n, i_wr, i_rd, o_power_save, o_osc_en;
  logic o_ext_clk_sel, o_hv_gen_en, o_bias_gen_en, o_frame_cal_run;
  logic o_vertical_addr, o_bit_order_sel, o_bottom_row_mirror;
  logic o_y_mirror, o_icon_row_en, o_p_four, o_ram_we;
  logic [1:0] o_pix_mode;
  logic [2:0] o_temp_coeff_sel, o_pump_mult;
  logic [3:0] i_addr, o_icon_bank, o_ram_bank;
  logic [6:0] o_mux_rows, o_start_line, o_init_row, o_ram_col;
  logic [7:0] i_wdata, o_rdata, o_frame_rate_hz;
  logic [7:0] o_supply_prog_value, o_ram_wdata, r;
  logic [18:0] ramq[$];
  logic [11:0] sq[24] = '{12'h302, 12'h4A5, 12'h041, 12'h043, 12'h047,
    12'h045, 12'h044, 12'h080, 12'h071, 12'h708, 12'h748, 12'h70C,
    12'h750, 12'h84E, 12'h204, 12'h710, 12'h718, 12'h84F, 12'h214,
    12'h200, 12'h57F, 12'h608, 12'h088, 12'h60A};
  int miscompares, total_checks, cyc, i;
  int m_disp, m_e0, m_e1, m_hv, m_vpr, m_col, m_bank, m_sl, m_ir, m_mux;
  int e_ps, e_osc, e_hv, e_p4;

  lcd_drv_config_state uut (.*);
  lcd_host_model host (.i_core_clk(i_core_clk), .i_rdata(o_rdata),
    .o_rst_n(i_rst_n), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));

  // ========================================
  // Clock, timeout and RAM write capture
  initial
  begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (o_ram_we === 1'b1)
      ramq.push_back({o_ram_bank, o_ram_col, o_ram_wdata});
    if (cyc == 5000)
    begin
      miscompares++;
      final_report();
    end
  end

  // ========================================
  // Model and comparison
  task automatic final_report();
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  function automatic void mreset();
    m_disp = 128;
    m_e0 = 8'h8B;
    m_e1 = 0;
    m_hv = 0;
    m_vpr = 0;
    m_col = 0;
    m_bank = 0;
    m_sl = 0;
    m_ir = 0;
    m_mux = 80;
  endfunction

  task automatic chk();
    @(posedge i_core_clk);
    #1;
    e_ps = m_disp[7] || (!m_disp[0] && m_disp[2]);
    e_osc = !e_ps && m_disp[6];
    e_hv = e_osc && m_hv[1:0] != 0;
    e_p4 = m_e1[4] && (m_mux == 64 || m_mux == 80);
    ck(o_power_save, e_ps);
    ck(o_osc_en, e_osc);
    ck(o_bias_gen_en, e_osc);
    ck(o_hv_gen_en, e_hv);
    ck(o_frame_cal_run, e_osc && m_disp[5]);
    ck(o_pix_mode, !e_osc || !m_disp[0] ? 0 :
       m_disp[2] ? 3 : 1 + m_disp[1]);
    ck(o_y_mirror, m_disp[4]);
    ck(o_frame_rate_hz, 30 + 10 * m_e0[1:0]);
    ck(o_temp_coeff_sel, m_e0[4:2]);
    ck(o_pump_mult, m_e0[7] ? m_e0[7:5] : m_e0[7:5] + 2);
    ck(o_supply_prog_value, m_vpr);
    ck(o_vertical_addr, m_e1[0]);
    ck(o_bit_order_sel, m_e1[1]);
    ck(o_icon_row_en, m_e1[2]);
    ck(o_bottom_row_mirror, m_e1[3]);
    ck(o_ext_clk_sel, m_e1[5]);
    ck(o_p_four, e_p4);
    ck(o_mux_rows, m_mux);
    ck(o_start_line, m_sl);
    ck(o_init_row, m_ir);
    ck(o_icon_bank, 9);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic [18:0] e;
    int st;
    st = (m_e1[2] || (m_mux % 16 == 0 && m_mux != 64 && m_mux != 80)) ?
         16 : 8;
    host.wr(a, v);
    case (a)
      4'h0: m_disp = v;
      4'h1: m_e0 = v;
      4'h2: m_e1 = v;
      4'h3: m_hv = v;
      4'h4: m_vpr = v;
      4'h5: m_col = v;
      4'h6: if (v <= 9) m_bank = v;
      4'h7: if (v % st == 0 && v != 72 && v < 80) m_sl = v;
      4'h8: if (v < 80 && !(m_e1[2] && v == 79)) m_ir = v;
      4'h9: if (v % 8 == 0 && v != 0 && v <= 80) m_mux = v;
      4'hA: mreset();
      4'hC:
      begin
        e = {4'(m_bank), m_disp[3] ? 7'(127 - m_col) : 7'(m_col), v};
        if (!m_e1[0])
          m_col = (m_col + 1) % 128;
        if (m_e1[0] || m_col == 0)
          m_bank = (m_bank + 1) % 10;
        if (m_e1[0] && m_bank == 0)
          m_col = (m_col + 1) % 128;
      end
      default: ;
    endcase
    chk();
    if (a == 4'hC)
      ck(ramq.pop_front(), e);
    ck(ramq.size(), 0);
  endtask

  // ========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h7514));
    mreset();
    host.pin_reset();
    chk();
    for (i = 0; i < 8; i++)
      wr(4'h1, {i[2:0], 3'($urandom), i[1:0]});
    for (i = 0; i < 12; i++)
      wr(4'h2, 8'($urandom) & 8'h3F);
    wr(4'h2, 8'h10);
    wr(4'h9, 8'h40);
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h38);
    wr(4'h9, 8'h30);
    wr(4'h7, 8'h08);
    wr(4'h7, 8'h20);
    wr(4'h9, 8'h50);
    for (i = 0; i < 24; i++)
    begin
      if (i == 19)
      begin
        host.rd(4'hB, r);
        ck(r, e_p4 * 16 + e_hv * 8 + e_osc * 4 + m_disp[0] * 2 + e_ps);
      end
      wr(sq[i][11:8], sq[i][7:0]);
    end
    for (i = 0; i < 5; i++)
    begin
      if (i == 3)
        wr(4'h2, 8'h01);
      wr(4'hC, 8'($urandom));
    end
    host.rd(4'hF, r);
    ck(r, 0);
    wr(4'hA, 8'h5A);
    wr(4'h2, 8'h3F);
    host.pin_reset();
    mreset();
    chk();
    final_report();
  end
endmodule

bind lcd_drv_config_state lcd_cfg_checker chk_i (.*);
